// File: cps_pkg.sv
// constants, register map and carrier types of the codec path power sequencer
// assumes one 100 MHz system clock and a synchronous active-high reset
package cps_pkg;

  // ==========================================================================
  // register map (byte offsets on the apb bus)
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFF_POWER  = 8'h00;
  localparam logic [7:0]  OFF_PATH   = 8'h04;
  localparam logic [7:0]  OFF_INPUT_VOLUME_GAIN   = 8'h08;
  localparam logic [7:0]  OFF_DVOL   = 8'h0c;
  localparam logic [7:0]  OFF_STATUS = 8'h10;
  localparam logic [7:0]  OFF_GAIN   = 8'h14;

  // ==========================================================================
  // field layouts and reset values
  localparam int unsigned POWER_W    = 9;
  localparam int unsigned PATH_W     = 13;
  localparam int unsigned VOL_W      = 8;
  localparam int unsigned STATUS_W   = 5;
  localparam int unsigned DATA_W     = 16;
  localparam logic [8:0]  POWER_RESET = 9'h000;
  // only the volume link bit is set after reset
  localparam logic [12:0] PATH_RESET  = 13'h0020;
  // 0dB code plus 80 steps of 0.375dB gives +30dB
  localparam logic [7:0]  INPUT_VOLUME_GAIN_RESET  = 8'he1;
  localparam logic [7:0]  INPUT_VOLUME_GAIN_0DB    = 8'h91;
  localparam logic [7:0]  DVOL_0DB    = 8'h18;
  localparam logic [7:0]  GAIN_MAX    = 8'hf1;
  localparam logic [7:0]  GAIN_MIN    = 8'h00;

  // ==========================================================================
  // timing: initialization cycles counted in sample periods
  localparam int unsigned INIT_W       = 11;
  localparam logic [10:0] INIT_SAMPLES = 11'd1059;

  typedef struct packed {
    logic line_amp_power;
    logic headphone_right_power;
    logic headphone_left_power;
    logic mixer_input_power;
    logic dac_power;
    logic adc_right_power;
    logic adc_left_power;
    logic mic_bias_power;
    logic reference_power;
  } cps_power_s;

  typedef struct packed {
    logic       ext_master_mode;
    logic [3:0] sample_rate_select;
    logic [1:0] bass_boost_level;
    logic       output_volume_link;
    logic       auto_level_enable;
    logic       headphone_common_voltage_on;
    logic       line_power_save;
    logic       dac_to_line_path;
    logic       dac_to_headphone_path;
  } cps_path_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cps_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cps_apb_rsp_s;

endpackage

// File: cps_init_timer.sv
// counts an initialization cycle of a fixed number of sample periods
// assumes sample_tick is a one-cycle pulse once per sample period
module cps_init_timer (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic keep,
  input  wire logic sample_tick,
  output logic      busy
);

  logic [cps_pkg::INIT_W-1:0] count_q;
  logic [cps_pkg::INIT_W-1:0] count_d;
  logic                       busy_d;
  wire                        last_tick = sample_tick && (count_q == 11'd1);

  assign count_d = start ? cps_pkg::INIT_SAMPLES :
                   (busy && sample_tick) ? count_q - 11'd1 : count_q;
  // dropping power mid-cycle abandons the cycle
  assign busy_d  = start || (busy && keep && !last_tick);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_q <= '0;
      busy    <= 1'b0;
    end else begin
      count_q <= count_d;
      busy    <= busy_d;
    end
  end

endmodule

// File: cps_vol_ramp.sv
// soft volume transition: one code step per sample period toward the target
// assumes restart is a one-cycle pulse at converter power-up
module cps_vol_ramp (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       restart,
  input  wire logic       run,
  input  wire logic       sample_tick,
  input  wire logic [7:0] target,
  output logic      [7:0] level
);

  logic [7:0] level_d;
  wire        go_up   = level < target;
  wire        go_down = level > target;

  assign level_d = restart                            ? cps_pkg::DVOL_0DB :
                   (run && sample_tick && go_up)   ? level + 8'h01 :
                   (run && sample_tick && go_down) ? level - 8'h01 : level;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level <= cps_pkg::DVOL_0DB;
    end else begin
      level <= level_d;
    end
  end

endmodule

// File: cps_sequencer.sv
// codec path power sequencer: apb control registers, converter init cycles,
// level-control gain handling, soft output volume and clock hold
// assumes all inputs synchronous to clk_sys; sample_tick pulses once per fs
module cps_sequencer (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 power_down_n,
  input  wire cps_pkg::cps_apb_req_s apb_req,
  output cps_pkg::cps_apb_rsp_s     apb_rsp,
  input  wire logic                 sample_tick,
  input  wire logic                 alc_raise,
  input  wire logic                 alc_lower,
  input  wire logic [15:0]          dac_in_left,
  input  wire logic [15:0]          dac_in_right,
  input  wire logic                 master_clock_present,
  input  wire logic                 bit_clock_gen,
  input  wire logic                 frame_clock_gen,
  output cps_pkg::cps_power_s       power_ctrl,
  output cps_pkg::cps_path_s        path_ctrl,
  output logic [15:0]               dac_out_left,
  output logic [15:0]               dac_out_right,
  output logic [7:0]                input_gain_left,
  output logic [7:0]                input_gain_right,
  output logic [7:0]                output_volume_level_left,
  output logic [7:0]                output_volume_level_right,
  output logic                      adc_data_valid,
  output logic                      bit_clock,
  output logic                      frame_clock
);

  // ==========================================================================
  // registers
  cps_pkg::cps_power_s  pwr_q;
  cps_pkg::cps_path_s   path_q;
  logic [7:0]           input_volume_left_q;
  logic [7:0]           input_volume_right_q;
  logic [7:0]           output_volume_left_q;
  logic [7:0]           output_volume_right_q;
  logic [7:0]           alc_gain_left_q;
  logic [7:0]           alc_gain_right_q;
  logic                 adc_any_prev_q;
  logic                 dac_prev_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [31:0]          prdata_q;
  logic                 adc_valid_q;
  logic [15:0]          dac_out_left_q;
  logic [15:0]          dac_out_right_q;
  logic                 bit_clock_q;
  logic                 frame_clock_q;

  // the pin clears everything just like the reset does
  wire reg_clear = rst || !power_down_n;

  // ==========================================================================
  // apb decode
  wire setup_phase = apb_req.psel && !apb_req.penable;
  wire wr_en       = apb_req.psel && apb_req.penable && pready_q && apb_req.pwrite;
  wire hit_power   = apb_req.paddr == cps_pkg::OFF_POWER;
  wire hit_path    = apb_req.paddr == cps_pkg::OFF_PATH;
  wire hit_input_volume_gain    = apb_req.paddr == cps_pkg::OFF_INPUT_VOLUME_GAIN;
  wire hit_dvol    = apb_req.paddr == cps_pkg::OFF_DVOL;
  wire hit_status  = apb_req.paddr == cps_pkg::OFF_STATUS;
  wire hit_gain    = apb_req.paddr == cps_pkg::OFF_GAIN;
  wire addr_ok     = hit_power || hit_path || hit_input_volume_gain || hit_dvol || hit_status || hit_gain;

  // ==========================================================================
  // sequencing state
  wire adc_any    = pwr_q.adc_left_power || pwr_q.adc_right_power;
  wire adc_rise   = adc_any && !adc_any_prev_q;
  wire dac_rise   = pwr_q.dac_power && !dac_prev_q;
  wire dac_start  = dac_rise && !adc_any;
  wire adc_busy;
  wire dac_busy;
  // level control sleeps while the record path is off or an init runs
  wire alc_active = path_q.auto_level_enable && adc_any && !dac_busy && !adc_busy;
  // link makes the left field the target for both channels
  wire [7:0] target_right = path_q.output_volume_link ? output_volume_left_q
                                                      : output_volume_right_q;
  wire [7:0] vol_left;
  wire [7:0] vol_right;

  wire [cps_pkg::STATUS_W-1:0] status_word = {alc_active, adc_valid_q, dac_busy,
                                              adc_busy, path_q.auto_level_enable};
  wire [31:0] rd_data =
    hit_power  ? {23'h000000, pwr_q} :
    hit_path   ? {19'h00000, path_q} :
    hit_input_volume_gain   ? {16'h0000, input_volume_right_q, input_volume_left_q} :
    hit_dvol   ? {16'h0000, output_volume_right_q, output_volume_left_q} :
    hit_status ? {27'h0000000, status_word} :
    hit_gain   ? {vol_right, vol_left, input_gain_right, input_gain_left} : 32'h00000000;

  // ==========================================================================
  // apb slave: zero wait states, data prepared during the setup cycle
  always_ff @(posedge clk_sys) begin
    if (reg_clear) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase && !addr_ok;
      prdata_q  <= (setup_phase && !apb_req.pwrite) ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reg_clear) begin
      pwr_q                 <= cps_pkg::POWER_RESET;
      path_q                <= cps_pkg::PATH_RESET;
      input_volume_left_q   <= cps_pkg::INPUT_VOLUME_GAIN_RESET;
      input_volume_right_q  <= cps_pkg::INPUT_VOLUME_GAIN_RESET;
      output_volume_left_q  <= cps_pkg::DVOL_0DB;
      output_volume_right_q <= cps_pkg::DVOL_0DB;
    end else if (wr_en) begin
      if (hit_power) pwr_q <= apb_req.pwdata[cps_pkg::POWER_W-1:0];
      if (hit_path) path_q <= apb_req.pwdata[cps_pkg::PATH_W-1:0];
      if (hit_input_volume_gain) begin
        input_volume_left_q  <= apb_req.pwdata[7:0];
        input_volume_right_q <= apb_req.pwdata[15:8];
      end
      if (hit_dvol) begin
        output_volume_left_q  <= apb_req.pwdata[7:0];
        output_volume_right_q <= apb_req.pwdata[15:8];
      end
    end
  end

  // ==========================================================================
  // converter initialization cycles
  cps_init_timer u_adc_init (
    .clk_sys     (clk_sys),
    .rst         (reg_clear),
    .start       (adc_rise),
    .keep        (adc_any),
    .sample_tick (sample_tick),
    .busy        (adc_busy)
  );

  cps_init_timer u_dac_init (
    .clk_sys     (clk_sys),
    .rst         (reg_clear),
    .start       (dac_start),
    .keep        (pwr_q.dac_power),
    .sample_tick (sample_tick),
    .busy        (dac_busy)
  );

  always_ff @(posedge clk_sys) begin
    if (reg_clear) begin
      adc_any_prev_q  <= 1'b0;
      dac_prev_q      <= 1'b0;
      adc_valid_q     <= 1'b0;
      dac_out_left_q  <= '0;
      dac_out_right_q <= '0;
    end else begin
      adc_any_prev_q  <= adc_any;
      dac_prev_q      <= pwr_q.dac_power;
      adc_valid_q     <= adc_any && !adc_busy && !adc_rise;
      // init forces two's-complement zero, then data passes through
      dac_out_left_q  <= (dac_busy || !pwr_q.dac_power) ? 16'h0000 : dac_in_left;
      dac_out_right_q <= (dac_busy || !pwr_q.dac_power) ? 16'h0000 : dac_in_right;
    end
  end

  // ==========================================================================
  // level-control gain; the input volume registers are cleared only by reset or the pin, not by
  // converter power-down, so a power-up reloads the stored setting
  always_ff @(posedge clk_sys) begin
    if (reg_clear) begin
      alc_gain_left_q  <= cps_pkg::INPUT_VOLUME_GAIN_RESET;
      alc_gain_right_q <= cps_pkg::INPUT_VOLUME_GAIN_RESET;
    end else if (adc_rise || dac_busy) begin
      alc_gain_left_q  <= input_volume_left_q;
      alc_gain_right_q <= input_volume_right_q;
    end else if (alc_active && sample_tick) begin
      if (alc_raise && alc_gain_left_q != cps_pkg::GAIN_MAX) begin
        alc_gain_left_q  <= alc_gain_left_q + 8'h01;
        alc_gain_right_q <= alc_gain_right_q + 8'h01;
      end else if (alc_lower && alc_gain_left_q != cps_pkg::GAIN_MIN) begin
        alc_gain_left_q  <= alc_gain_left_q - 8'h01;
        alc_gain_right_q <= alc_gain_right_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reg_clear) begin
      input_gain_left  <= cps_pkg::INPUT_VOLUME_GAIN_RESET;
      input_gain_right <= cps_pkg::INPUT_VOLUME_GAIN_RESET;
    end else begin
      input_gain_left  <= path_q.auto_level_enable ? alc_gain_left_q : input_volume_left_q;
      input_gain_right <= path_q.auto_level_enable ? alc_gain_right_q : input_volume_right_q;
    end
  end

  // ==========================================================================
  // soft output volume
  cps_vol_ramp u_ramp_left (
    .clk_sys     (clk_sys),
    .rst         (reg_clear),
    .restart     (dac_rise),
    .run         (pwr_q.dac_power),
    .sample_tick (sample_tick),
    .target      (output_volume_left_q),
    .level       (vol_left)
  );

  cps_vol_ramp u_ramp_right (
    .clk_sys     (clk_sys),
    .rst         (reg_clear),
    .restart     (dac_rise),
    .run         (pwr_q.dac_power),
    .sample_tick (sample_tick),
    .target      (target_right),
    .level       (vol_right)
  );

  // ==========================================================================
  // serial clocks; a stopped master clock in master mode freezes both
  wire clk_hold = path_q.ext_master_mode && !master_clock_present;

  always_ff @(posedge clk_sys) begin
    if (reg_clear) begin
      bit_clock_q   <= 1'b0;
      frame_clock_q <= 1'b0;
    end else if (!clk_hold) begin
      bit_clock_q   <= bit_clock_gen;
      frame_clock_q <= frame_clock_gen;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reg_clear) begin
      output_volume_level_left  <= cps_pkg::DVOL_0DB;
      output_volume_level_right <= cps_pkg::DVOL_0DB;
    end else begin
      output_volume_level_left  <= vol_left;
      output_volume_level_right <= vol_right;
    end
  end

  assign apb_rsp    = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};
  assign power_ctrl = pwr_q;
  assign path_ctrl  = path_q;
  assign dac_out_left   = dac_out_left_q;
  assign dac_out_right  = dac_out_right_q;
  assign adc_data_valid = adc_valid_q;
  assign bit_clock      = bit_clock_q;
  assign frame_clock    = frame_clock_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reg_clear);

  chk_adc_init_start: assert property (adc_rise |=> adc_busy && !adc_valid_q)
    else $error("adc init did not start on record power-up");
  chk_adc_busy_invalid: assert property (adc_busy |=> !adc_valid_q)
    else $error("adc data valid during init");
  chk_alc_start_gain: assert property (
    adc_rise |=> alc_gain_left_q == $past(input_volume_left_q))
    else $error("level gain not loaded at record power-up");
  chk_alc_off_hold: assert property (
    (!adc_any && !dac_busy) |=> $stable(alc_gain_left_q))
    else $error("level gain moved with adcs off");
  chk_dac_init_start: assert property (dac_start |=> dac_busy)
    else $error("dac init did not start");
  chk_dac_init_skip: assert property ((dac_rise && adc_any) |=> !dac_busy)
    else $error("dac init ran with an adc powered");
  chk_dac_zero_data: assert property (
    dac_busy |=> dac_out_left_q == 16'h0000 && dac_out_right_q == 16'h0000)
    else $error("dac data not zero during init");
  chk_alc_init_gain: assert property (
    dac_busy |=> alc_gain_right_q == $past(input_volume_right_q))
    else $error("level gain not held at input volume");
  chk_vol_link_pair: assert property (
    (path_q.output_volume_link && vol_left == vol_right) |=> vol_left == vol_right)
    else $error("linked volumes diverged");
  chk_soft_step: assert property (
    (!$past(dac_rise) && !$past(reg_clear) && vol_left != $past(vol_left)) |->
      (vol_left - $past(vol_left) == 8'h01) || ($past(vol_left) - vol_left == 8'h01))
    else $error("volume stepped by more than one code");
  chk_clk_hold: assert property (
    clk_hold |=> $stable(bit_clock_q) && $stable(frame_clock_q))
    else $error("serial clocks moved without master clock");
  chk_pdn_clear: assert property (@(posedge clk_sys) disable iff (rst)
    !power_down_n |=> pwr_q == cps_pkg::POWER_RESET && path_q == cps_pkg::PATH_RESET)
    else $error("power-down pin did not clear registers");

  cov_adc_power_up: cover property (adc_rise ##1 adc_busy);
  cov_dac_init_done: cover property (dac_busy ##1 !dac_busy && pwr_q.dac_power);
  cov_dac_skip: cover property (dac_rise && adc_any);
  cov_clock_hold: cover property (clk_hold ##1 clk_hold);

endmodule

// File: cps_host_model.sv
// host controller model: apb master that writes and reads the control registers
// assumes the sequencer answers each access cycle with pready, as stated
module cps_host_model (
  input  wire logic                  clk_sys,
  output cps_pkg::cps_apb_req_s      apb_req,
  input  wire cps_pkg::cps_apb_rsp_s apb_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        rd;
    logic [31:0] data;
    logic        err;
  } cps_note_s;

  // ==========================================================================
  // expected answers, oldest first, taken off by the bench monitor
  cps_note_s exp_q[$];

  initial apb_req = '0;

  // setup starts on the next rising edge; request held until pready is sampled high
  // the caller keeps host ordering; level control and rate stay untouched
  // while converters run, so no relock or parameter hazard arises
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      input logic [31:0] exp, input logic err);
    exp_q.push_back('{!wr, exp, err});
    @(posedge clk_sys);
    apb_req <= '{1'b1, 1'b0, wr, addr, wdata};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
    apb_req <= '0;
  endtask
endmodule

// File: cps_sequencer_tb.sv
// self-checking bench of the codec path power sequencer
// assumes the host model drives apb and this module drives all other inputs
module cps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0, rst = 1'b1, power_down_n = 1'b1, sample_tick = 1'b0;
  logic alc_raise = 1'b0, alc_lower = 1'b0, master_clock_present = 1'b1;
  logic bit_clock_gen = 1'b0, frame_clock_gen = 1'b0;
  logic [15:0] dac_in_left = 16'h0001, dac_in_right = 16'h0001, dac_out_left, dac_out_right;
  logic [7:0] input_gain_left, input_gain_right, vol_left, vol_right, g;
  logic [1:0] tick_div = 2'h0;
  logic adc_data_valid, bit_clock, frame_clock, b, f;
  cps_pkg::cps_apb_req_s apb_req;
  cps_pkg::cps_apb_rsp_s apb_rsp;
  cps_pkg::cps_power_s power_ctrl;
  cps_pkg::cps_path_s path_ctrl;
  int n_errors = 0, check_count = 0;

  always #5 clk_sys = ~clk_sys;

  cps_host_model u_host (.clk_sys(clk_sys), .apb_req(apb_req), .apb_rsp(apb_rsp));

  cps_sequencer dut (.clk_sys(clk_sys), .rst(rst), .power_down_n(power_down_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .sample_tick(sample_tick), .alc_raise(alc_raise),
    .alc_lower(alc_lower), .dac_in_left(dac_in_left), .dac_in_right(dac_in_right),
    .master_clock_present(master_clock_present), .bit_clock_gen(bit_clock_gen),
    .frame_clock_gen(frame_clock_gen), .power_ctrl(power_ctrl), .path_ctrl(path_ctrl),
    .dac_out_left(dac_out_left), .dac_out_right(dac_out_right),
    .input_gain_left(input_gain_left), .input_gain_right(input_gain_right),
    .output_volume_level_left(vol_left), .output_volume_level_right(vol_right),
    .adc_data_valid(adc_data_valid), .bit_clock(bit_clock), .frame_clock(frame_clock));

  // ==========================================================================
  // sample rate 4 clocks; data is odd so forced zero is never mistaken for input
  always @(posedge clk_sys) begin
    tick_div <= tick_div + 2'h1;
    sample_tick <= (tick_div == 2'h3);
    bit_clock_gen <= ~bit_clock_gen;
    frame_clock_gen <= tick_div[1];
    if (tick_div == 2'h3) begin
      dac_in_left <= 16'($urandom) | 16'h0001;
      dac_in_right <= 16'($urandom) | 16'h0001;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    u_host.xfer(1'b1, a, d, 32'h0, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    u_host.xfer(1'b0, a, 32'h0, d, e);
  endtask

  task automatic wait_ticks(input int n);
    repeat (n) @(posedge clk_sys iff sample_tick === 1'b1);
  endtask

  // ==========================================================================
  // monitor: each answered access takes the oldest note
  always @(posedge clk_sys) begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 &&
        u_host.exp_q.size() > 0) begin
      check(32'(apb_rsp.pslverr), 32'(u_host.exp_q[0].err));
      if (u_host.exp_q[0].rd)
        check(apb_rsp.prdata, u_host.exp_q[0].data);
      void'(u_host.exp_q.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'hd421));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(cps_pkg::OFF_POWER, 32'h0);
    rd(cps_pkg::OFF_PATH, 32'h20);
    rd(cps_pkg::OFF_INPUT_VOLUME_GAIN, 32'he1e1);
    rd(cps_pkg::OFF_DVOL, 32'h1818);
    rd(8'h3c, 32'h0, 1'b1);
    wr(8'h3c, 32'hffff, 1'b1);
    $display("test reset_values done");
    // level control set before the record path wakes, bias ahead of adc
    wr(cps_pkg::OFF_PATH, 32'h30);
    wr(cps_pkg::OFF_POWER, 32'h003);
    wr(cps_pkg::OFF_POWER, 32'h007);
    // align to the edge at which the init counter loads
    @(posedge clk_sys);
    alc_raise <= 1'b1;
    #1 check(32'(input_gain_left), 32'he1);
    wait_ticks(1057);
    #1 check(32'(adc_data_valid), 32'h0);
    check(32'(input_gain_left), 32'he1);
    wait_ticks(4);
    #1 check(32'(adc_data_valid), 32'h1);
    rd(cps_pkg::OFF_STATUS, 32'h19);
    wait_ticks(4);
    #1 check(32'(input_gain_left > 8'he1), 32'h1);
    wr(cps_pkg::OFF_POWER, 32'h001);
    wait_ticks(1);
    #1 g = input_gain_left;
    wait_ticks(8);
    #1 check(32'(input_gain_left), 32'(g));
    rd(cps_pkg::OFF_STATUS, 32'h01);
    alc_raise <= 1'b0;
    wr(cps_pkg::OFF_POWER, 32'h005);
    repeat (2) @(posedge clk_sys);
    #1 check(32'(input_gain_left), 32'he1);
    wr(cps_pkg::OFF_POWER, 32'h001);
    $display("test record_path done");
    wr(cps_pkg::OFF_INPUT_VOLUME_GAIN, 32'h9191);
    wr(cps_pkg::OFF_DVOL, 32'h0030);
    wr(cps_pkg::OFF_POWER, 32'h031);
    @(posedge clk_sys);
    #1 check(32'(vol_left), 32'h18);
    wait_ticks(4);
    #1 check(32'(vol_left > 8'h18 && vol_left < 8'h30), 32'h1);
    wait_ticks(96);
    #1 check(32'(dac_out_left), 32'h0);
    check(32'(dac_out_right), 32'h0);
    check(32'(input_gain_left), 32'h91);
    check(32'(input_gain_right), 32'h91);
    rd(cps_pkg::OFF_STATUS, 32'h05);
    wait_ticks(950);
    rd(cps_pkg::OFF_STATUS, 32'h05);
    wait_ticks(9);
    repeat (2) @(posedge clk_sys);
    #1 check(32'(dac_out_left), 32'(dac_in_left));
    check(32'(dac_out_right), 32'(dac_in_right));
    check(32'(vol_left), 32'h30);
    check(32'(vol_right), 32'h30);
    rd(cps_pkg::OFF_STATUS, 32'h01);
    $display("test dac_init done");
    // headphone and line outputs brought up and down in host order
    wr(cps_pkg::OFF_POWER, 32'h0f1);
    wr(cps_pkg::OFF_PATH, 32'h39);
    rd(cps_pkg::OFF_PATH, 32'h39);
    wr(cps_pkg::OFF_PATH, 32'h31);
    wait_ticks(8);
    wr(cps_pkg::OFF_POWER, 32'h031);
    wr(cps_pkg::OFF_PATH, 32'h36);
    wr(cps_pkg::OFF_POWER, 32'h131);
    wait_ticks(8);
    wr(cps_pkg::OFF_PATH, 32'h32);
    rd(cps_pkg::OFF_POWER, 32'h131);
    wr(cps_pkg::OFF_PATH, 32'h36);
    wr(cps_pkg::OFF_POWER, 32'h001);
    wait_ticks(8);
    wr(cps_pkg::OFF_PATH, 32'h34);
    wr(cps_pkg::OFF_PATH, 32'h30);
    rd(cps_pkg::OFF_PATH, 32'h30);
    $display("test output_paths done");
    wr(cps_pkg::OFF_POWER, 32'h005);
    wr(cps_pkg::OFF_POWER, 32'h015);
    wait_ticks(2);
    repeat (2) @(posedge clk_sys);
    #1 check(32'(dac_out_left), 32'(dac_in_left));
    $display("test dac_skip done");
    // master clock stopped only with the converters idle
    wr(cps_pkg::OFF_POWER, 32'h001);
    wr(cps_pkg::OFF_PATH, 32'h1020);
    master_clock_present <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 b = bit_clock;
    f = frame_clock;
    repeat (9) @(posedge clk_sys);
    #1 check(32'(bit_clock), 32'(b));
    check(32'(frame_clock), 32'(f));
    wr(cps_pkg::OFF_POWER, 32'h0);
    master_clock_present <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check(32'(bit_clock), 32'(!bit_clock_gen));
    $display("test clock_hold done");
    wr(cps_pkg::OFF_INPUT_VOLUME_GAIN, 32'h1234);
    power_down_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    power_down_n <= 1'b1;
    @(posedge clk_sys);
    rd(cps_pkg::OFF_PATH, 32'h20);
    rd(cps_pkg::OFF_INPUT_VOLUME_GAIN, 32'he1e1);
    rd(cps_pkg::OFF_DVOL, 32'h1818);
    #1 check(32'(power_ctrl), 32'h0);
    check(32'(path_ctrl), 32'h20);
    $display("test pin_reset done");
    tally_and_finish();
  end
endmodule
